// >>> logic/fsmm_monitor.sv
// Purpose: four-sensor sequential muting machine with error reporting
// Assumes: classic wishbone slave, pins synchronised inside
// Notes: one execution cycle per ref_clk edge, times in milliseconds
// Functional notes
// - sensors changing out of legal forward or backward order raise sequence error
// - sequence started without process permit reports code CFx4
// - lamp_ok_in low in a muting state (8011, 8012, 8122, 8112) enters lamp error with code C003
// - reset already high entering 8001 reports C001
// - reset already high entering 8003 reports C002
// - max bypass time below zero or above ten minutes gives C005
// - time only while bypass active; overrun gives C006
// - error states: guard and bypass off, error and ready on, code out
// - resume only after cause cleared and a fresh operator reset
// - sequence code is C, state nibble Y, sensor nibble, 4
// - sequence error in backward active 8112 uses nibble 4
// - sensor nibble bits: a1, a2, b1, b2 from bit 0
// - activate low returns to idle from anywhere, highest priority
// - muting priority: sequence, timer, curtain, lamp, then normal steps
// - forward start on permitted a1 rise alone, then a2 rise to 8012
// - in 8000 ready and guard on, bypass and error off
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "fsmm_defines.svh"
module fsmm_monitor #(
    parameter int TICK_CYCLES = `FSMM_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sensor_a1,
    input wire logic sensor_a2,
    input wire logic sensor_b1,
    input wire logic sensor_b2,
    input wire logic process_permit,
    input wire logic lamp_ok_in,
    input wire logic curtain_in,
    input wire logic reset_in,
    output logic guard_ok_out,
    output logic bypass_active_out,
    output logic ready_out,
    output logic error_out,
    output fsmm_pkg::fsmm_code_t diag_code_out,
    output logic irq_out
);
    import fsmm_pkg::*;

    // pin synchronisers
    logic [7:0] pinSync;
    fsmm_sync #(.WIDTH(8)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pinIn({reset_in, curtain_in, lamp_ok_in, process_permit,
            sensor_b2, sensor_b1, sensor_a2, sensor_a1}),
        .syncOut(pinSync)
    );

    logic [7:0] prevReg;
    fsmm_state_e stateReg;
    fsmm_state_e stateNext;
    fsmm_state_e prevStateReg;
    logic ctrlReg;
    logic [31:0] maxTimeReg;
    logic [31:0] elapsedReg;
    logic [31:0] tickCntReg;
    logic [`FSMM_IRQ_W-1:0] irqStatReg;
    logic [`FSMM_IRQ_W-1:0] irqMaskReg;
    fsmm_code_t diagNext;
    fsmm_code_t seqCode;

    wire [3:0] sens = pinSync[3:0];
    wire [3:0] sensRise = pinSync[3:0] & ~prevReg[3:0];
    wire [3:0] sensFall = ~pinSync[3:0] & prevReg[3:0];
    wire a1 = sens[0];
    wire a2 = sens[1];
    wire b1 = sens[2];
    wire b2 = sens[3];
    wire permit = pinSync[4];
    wire lampOk = pinSync[5];
    wire curtain = pinSync[6];
    wire rstIn = pinSync[7];
    wire rstRise = rstIn & ~prevReg[7];
    wire activate = ctrlReg;
    wire sensClear = (sens == 4'h0);
    wire entered = (stateReg != prevStateReg);

    // negative times show as a set sign bit
    wire paramBad = maxTimeReg[31]
        || (maxTimeReg > `FSMM_MAXT_LIMIT_MS);
    wire timerOver = (elapsedReg > maxTimeReg);
    wire tick = (tickCntReg == 32'(TICK_CYCLES - 1));
    wire bypassState = (stateReg == FSMM_FWDA)
        || (stateReg == FSMM_BWDA);

    // illegal sequences per state
    wire noPermitFree = !permit && (sensRise[0] || sensRise[3]);
    wire seqFree = a2 || b1 || (a1 && b2);
    wire seqFwds = !permit || !a1 || b1 || b2;
    wire seqFwda = sensRise[0] || sensRise[1] || sensFall[3];
    wire seqBwds = !permit || a1 || a2 || !b2;
    wire seqBwda = sensFall[0] || sensRise[2] || sensRise[3];
    wire startFwd = permit && sensRise[0] && !a2 && !b1 && !b2;
    wire stepFwd = permit && a1 && sensRise[1] && !b1 && !b2;
    wire endFwd = !a1 && !a2 && sensFall[2] && b2;
    wire startBwd = permit && !a1 && !a2 && !b1 && sensRise[3];
    wire stepBwd = permit && !a1 && !a2 && sensRise[2] && b2;
    wire endBwd = a1 && sensFall[1] && !b1 && !b2;

    // state nibble of a sequence error follows the state it hit
    logic [3:0] seqY;
    always_comb begin
        unique case (stateReg)
            FSMM_FWDS: seqY = `FSMM_Y_FWDS;
            FSMM_FWDA: seqY = `FSMM_Y_FWDA;
            FSMM_BWDS: seqY = `FSMM_Y_BWDS;
            FSMM_BWDA: seqY = `FSMM_Y_BWDA;
            default: seqY = noPermitFree ? `FSMM_Y_NOPERMIT
                : `FSMM_Y_FREE;
        endcase
    end
    assign seqCode = {`FSMM_SEQ_HI, seqY, b2, b1, a2, a1,
        `FSMM_SEQ_LO};

    // muting substates share one priority ladder
    function automatic fsmm_state_e muteStep(
        input logic seqBad,
        input logic timed,
        input logic curtainMuted,
        input logic normal,
        input fsmm_state_e normalTo,
        input fsmm_state_e stay
    );
        if (seqBad) begin
            muteStep = FSMM_ESEQ;
        end else if (timed && timerOver) begin
            muteStep = FSMM_ETIMER;
        end else if (!curtainMuted && !curtain) begin
            muteStep = FSMM_DEMAND;
        end else if (!lampOk) begin
            muteStep = FSMM_ELAMP;
        end else if (normal) begin
            muteStep = normalTo;
        end else begin
            muteStep = stay;
        end
    endfunction

    always_comb begin
        stateNext = stateReg;
        if (!activate) begin
            stateNext = FSMM_IDLE;
        end else if (paramBad && stateReg != FSMM_EPARAM) begin
            stateNext = FSMM_EPARAM;
        end else begin
            unique case (stateReg)
                FSMM_IDLE: stateNext = FSMM_INIT;
                FSMM_INIT: begin
                    if (entered && rstIn) begin
                        stateNext = FSMM_ERST1;
                    end else if (rstRise && curtain) begin
                        stateNext = FSMM_FREE;
                    end
                end
                FSMM_FREE: begin
                    if (noPermitFree || seqFree) begin
                        stateNext = FSMM_ESEQ;
                    end else if (!curtain) begin
                        stateNext = FSMM_DEMAND;
                    end else if (startFwd) begin
                        stateNext = FSMM_FWDS;
                    end else if (startBwd) begin
                        stateNext = FSMM_BWDS;
                    end
                end
                FSMM_FWDS: stateNext = muteStep(seqFwds, 1'b0, 1'b0,
                    stepFwd, FSMM_FWDA, FSMM_FWDS);
                FSMM_FWDA: stateNext = muteStep(seqFwda, 1'b1, 1'b1,
                    endFwd, FSMM_FREE, FSMM_FWDA);
                FSMM_BWDS: stateNext = muteStep(seqBwds, 1'b0, 1'b0,
                    stepBwd, FSMM_BWDA, FSMM_BWDS);
                FSMM_BWDA: stateNext = muteStep(seqBwda, 1'b1, 1'b1,
                    endBwd, FSMM_FREE, FSMM_BWDA);
                FSMM_DEMAND: begin
                    if (curtain) begin
                        stateNext = FSMM_WAITR;
                    end
                end
                FSMM_WAITR: begin
                    if (entered && rstIn) begin
                        stateNext = FSMM_ERST2;
                    end else if (rstRise && curtain) begin
                        stateNext = FSMM_FREE;
                    end
                end
                // errors leave only on a fresh reset edge, cause gone
                FSMM_ERST1, FSMM_ERST2: begin
                    if (rstRise && curtain) begin
                        stateNext = FSMM_FREE;
                    end
                end
                FSMM_ELAMP: begin
                    if (lampOk && rstRise && curtain) begin
                        stateNext = FSMM_FREE;
                    end
                end
                FSMM_ESEQ, FSMM_ETIMER: begin
                    if (sensClear && rstRise && curtain) begin
                        stateNext = FSMM_FREE;
                    end
                end
                FSMM_EPARAM: begin
                    if (!paramBad && rstRise) begin
                        stateNext = FSMM_FREE;
                    end
                end
                default: stateNext = FSMM_IDLE;
            endcase
        end
    end

    // output decode of the next state, registered below
    wire nextErr = (stateNext == FSMM_ERST1) || (stateNext == FSMM_ERST2)
        || (stateNext == FSMM_ELAMP) || (stateNext == FSMM_ESEQ)
        || (stateNext == FSMM_EPARAM) || (stateNext == FSMM_ETIMER);
    wire nextGuard = (stateNext == FSMM_FREE) || (stateNext == FSMM_FWDS)
        || (stateNext == FSMM_FWDA) || (stateNext == FSMM_BWDS)
        || (stateNext == FSMM_BWDA);
    wire nextBypass = (stateNext == FSMM_FWDA)
        || (stateNext == FSMM_BWDA);
    wire nextReady = (stateNext != FSMM_IDLE);

    always_comb begin
        unique case (stateNext)
            FSMM_IDLE: diagNext = `FSMM_CODE_IDLE;
            FSMM_INIT: diagNext = `FSMM_CODE_INIT;
            FSMM_FREE: diagNext = `FSMM_CODE_FREE;
            FSMM_FWDS: diagNext = `FSMM_CODE_FWDS;
            FSMM_FWDA: diagNext = `FSMM_CODE_FWDA;
            FSMM_BWDS: diagNext = `FSMM_CODE_BWDS;
            FSMM_BWDA: diagNext = `FSMM_CODE_BWDA;
            FSMM_DEMAND: diagNext = `FSMM_CODE_DEMAND;
            FSMM_WAITR: diagNext = `FSMM_CODE_WAITR;
            FSMM_ERST1: diagNext = `FSMM_CODE_RST1;
            FSMM_ERST2: diagNext = `FSMM_CODE_RST2;
            FSMM_ELAMP: diagNext = `FSMM_CODE_LAMP;
            FSMM_EPARAM: diagNext = `FSMM_CODE_PARAM;
            FSMM_ETIMER: diagNext = `FSMM_CODE_TIMER;
            // sensor nibble frozen at the moment of the error
            FSMM_ESEQ: diagNext = (stateReg == FSMM_ESEQ)
                ? diag_code_out : seqCode;
            default: diagNext = `FSMM_CODE_IDLE;
        endcase
    end

    // interrupt events
    wire [`FSMM_IRQ_W-1:0] irqEvent = {
        (stateNext == FSMM_DEMAND) && (stateReg != FSMM_DEMAND),
        (stateNext == FSMM_FREE) && bypassState,
        nextBypass && !bypassState,
        nextErr && !error_out
    };

    // wishbone decode
    wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wbWr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
    wire [31:0] selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wrData = wb_dat_i & selMask;
    wire wrCtrl = wbWr && (wb_adr_i == `FSMM_ADR_CTRL) && wb_sel_i[0];
    wire wrMaxt = wbWr && (wb_adr_i == `FSMM_ADR_MAXT);
    wire wrIrqs = wbWr && (wb_adr_i == `FSMM_ADR_IRQS);
    wire wrIrqm = wbWr && (wb_adr_i == `FSMM_ADR_IRQM) && wb_sel_i[0];
    wire [31:0] maxtNext = (maxTimeReg & ~selMask) | wrData;
    wire [`FSMM_IRQ_W-1:0] irqClr = wrIrqs
        ? wrData[`FSMM_IRQ_W-1:0] : '0;
    // a new event outranks a clear in the same cycle
    wire [`FSMM_IRQ_W-1:0] irqStatNext = (irqStatReg & ~irqClr) | irqEvent;
    logic [31:0] rdData;
    always_comb begin
        unique case (wb_adr_i)
            `FSMM_ADR_CTRL: rdData = {31'h0, ctrlReg};
            `FSMM_ADR_MAXT: rdData = maxTimeReg;
            `FSMM_ADR_STAT: rdData = {12'h000, bypass_active_out,
                guard_ok_out, error_out, ready_out, diag_code_out};
            `FSMM_ADR_IRQS: rdData = {28'h0, irqStatReg};
            `FSMM_ADR_IRQM: rdData = {28'h0, irqMaskReg};
            `FSMM_ADR_TIME: rdData = elapsedReg;
            default: rdData = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrlReg <= 1'b0;
            maxTimeReg <= `FSMM_MAXT_RST;
            irqStatReg <= '0;
            irqMaskReg <= '0;
            irq_out <= 1'b0;
        end else begin
            wb_ack_o <= wbReq;
            wb_dat_o <= wbReq ? rdData : 32'h0000_0000;
            ctrlReg <= wrCtrl ? wb_dat_i[`FSMM_CTRL_ACT] : ctrlReg;
            maxTimeReg <= wrMaxt ? maxtNext : maxTimeReg;
            irqStatReg <= irqStatNext;
            irqMaskReg <= wrIrqm ? wb_dat_i[`FSMM_IRQ_W-1:0] : irqMaskReg;
            irq_out <= |(irqStatNext & irqMaskReg);
        end
    end

    // bypass timer: millisecond ticks only while bypass is active
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCntReg <= 32'h0000_0000;
            elapsedReg <= 32'h0000_0000;
        end else if (!bypassState) begin
            tickCntReg <= 32'h0000_0000;
            elapsedReg <= 32'h0000_0000;
        end else begin
            tickCntReg <= tick ? 32'h0000_0000 : tickCntReg + 32'h1;
            elapsedReg <= tick ? elapsedReg + 32'h1 : elapsedReg;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevReg <= 8'h00;
            stateReg <= FSMM_IDLE;
            prevStateReg <= FSMM_IDLE;
            guard_ok_out <= 1'b0;
            bypass_active_out <= 1'b0;
            ready_out <= 1'b0;
            error_out <= 1'b0;
            diag_code_out <= `FSMM_CODE_IDLE;
        end else begin
            prevReg <= pinSync;
            stateReg <= stateNext;
            prevStateReg <= stateReg;
            guard_ok_out <= nextGuard;
            bypass_active_out <= nextBypass;
            ready_out <= nextReady;
            error_out <= nextErr;
            diag_code_out <= diagNext;
        end
    end
endmodule

// >>> logic/fsmm_defines.svh
// Purpose: named constants for the four-sensor muting error monitor
// Assumes: 100 MHz ref_clk, times kept in milliseconds
// Notes: definitions only
`ifndef FSMM_DEFINES_SVH
`define FSMM_DEFINES_SVH

`define FSMM_CLK_NS 10
`define FSMM_MS_NS 1000000
`define FSMM_TICK_CYCLES (`FSMM_MS_NS / `FSMM_CLK_NS)
`define FSMM_MAXT_LIMIT_MS 32'h0009_27C0
`define FSMM_MAXT_RST 32'h0000_2710

`define FSMM_ADR_CTRL 8'h00
`define FSMM_ADR_MAXT 8'h04
`define FSMM_ADR_STAT 8'h08
`define FSMM_ADR_IRQS 8'h0C
`define FSMM_ADR_IRQM 8'h10
`define FSMM_ADR_TIME 8'h14

`define FSMM_CTRL_ACT 0
`define FSMM_IRQ_W 4
`define FSMM_IRQ_ERR 0
`define FSMM_IRQ_MSTART 1
`define FSMM_IRQ_MEND 2
`define FSMM_IRQ_DEMAND 3

`define FSMM_CODE_IDLE 16'h0000
`define FSMM_CODE_FREE 16'h8000
`define FSMM_CODE_INIT 16'h8001
`define FSMM_CODE_DEMAND 16'h8002
`define FSMM_CODE_WAITR 16'h8003
`define FSMM_CODE_FWDS 16'h8011
`define FSMM_CODE_FWDA 16'h8012
`define FSMM_CODE_BWDS 16'h8122
`define FSMM_CODE_BWDA 16'h8112
`define FSMM_CODE_RST1 16'hC001
`define FSMM_CODE_RST2 16'hC002
`define FSMM_CODE_LAMP 16'hC003
`define FSMM_CODE_PARAM 16'hC005
`define FSMM_CODE_TIMER 16'hC006
`define FSMM_SEQ_HI 4'hC
`define FSMM_SEQ_LO 4'h4
`define FSMM_Y_FREE 4'h0
`define FSMM_Y_FWDS 4'h1
`define FSMM_Y_FWDA 4'h2
`define FSMM_Y_BWDS 4'h3
`define FSMM_Y_BWDA 4'h4
`define FSMM_Y_NOPERMIT 4'hF

`endif

// >>> logic/fsmm_pkg.sv
// Purpose: types for the four-sensor muting error monitor
// Assumes: nothing beyond the defines header
// Notes: gray codes run along the usual path
package fsmm_pkg;
    typedef enum logic [3:0] {
        FSMM_IDLE = 4'h0,
        FSMM_INIT = 4'h1,
        FSMM_FREE = 4'h3,
        FSMM_FWDS = 4'h2,
        FSMM_FWDA = 4'h6,
        FSMM_BWDS = 4'h7,
        FSMM_BWDA = 4'h5,
        FSMM_DEMAND = 4'h4,
        FSMM_WAITR = 4'hC,
        FSMM_ERST1 = 4'hD,
        FSMM_ERST2 = 4'hF,
        FSMM_ELAMP = 4'hE,
        FSMM_ESEQ = 4'hA,
        FSMM_EPARAM = 4'hB,
        FSMM_ETIMER = 4'h9
    } fsmm_state_e;
    typedef logic [15:0] fsmm_code_t;
endpackage

// >>> logic/fsmm_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous pins
// Notes: output moves only once stages two and three agree
`timescale 1ns/1ps
module fsmm_sync #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1Reg;
    logic [WIDTH-1:0] stage2Reg;
    logic [WIDTH-1:0] stage3Reg;
    wire [WIDTH-1:0] agreeMask = ~(stage2Reg ^ stage3Reg);
    wire [WIDTH-1:0] syncNext = (stage3Reg & agreeMask)
        | (syncOut & ~agreeMask);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1Reg <= '0;
            stage2Reg <= '0;
            stage3Reg <= '0;
            syncOut <= '0;
        end else begin
            stage1Reg <= pinIn;
            stage2Reg <= stage1Reg;
            stage3Reg <= stage2Reg;
            syncOut <= syncNext;
        end
    end
endmodule

// >>> test/fsmm_field.sv
// Purpose: field side: sensors, curtain, lamp, operator
// Assumes: changes land just after ref_clk rises
// Notes: levels held between calls
`timescale 1ns/1ps
module fsmm_field (
    input logic ref_clk,
    output logic sensor_a1,
    output logic sensor_a2,
    output logic sensor_b1,
    output logic sensor_b2,
    output logic process_permit,
    output logic lamp_ok_in,
    output logic curtain_in,
    output logic reset_in
);
    initial begin
        {sensor_b2, sensor_b1, sensor_a2, sensor_a1} = 4'h0;
        process_permit = 1'b1;
        lamp_ok_in = 1'b1;
        curtain_in = 1'b1;
        reset_in = 1'b0;
    end
    task automatic setPins(input logic [3:0] s);
        @(posedge ref_clk);
        {sensor_b2, sensor_b1, sensor_a2, sensor_a1} <= s;
    endtask
    task automatic setCtl(input logic p, input logic l, input logic c);
        @(posedge ref_clk);
        process_permit <= p;
        lamp_ok_in <= l;
        curtain_in <= c;
    endtask
    task automatic setReset(input logic r);
        @(posedge ref_clk);
        reset_in <= r;
    endtask
    task automatic ackReset(input int hold);
        setReset(1'b0);
        repeat (hold) @(posedge ref_clk);
        setReset(1'b1);
        repeat (hold) @(posedge ref_clk);
        setReset(1'b0);
    endtask
endmodule

// >>> test/fsmm_chk_monitor.sv
// Purpose: port-level checks of the muting monitor
// Assumes: registered outputs, entry seen against $past
// Notes: bound into fsmm_monitor below
`timescale 1ns/1ps
module fsmm_chk #(
    parameter int TICK_CYCLES = 10
) (
    input logic ref_clk,
    input logic rst_n,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    input logic guard_ok_out,
    input logic bypass_active_out,
    input logic ready_out,
    input logic error_out,
    input fsmm_pkg::fsmm_code_t diag_code_out
);
    import fsmm_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence errRise(logic [15:0] code);
        $rose(error_out) && diag_code_out == code;
    endsequence
    sequence seqRise(logic [3:0] y);
        $rose(error_out) && diag_code_out[15:8] == {4'hC, y}
            && diag_code_out[3:0] == 4'h4;
    endsequence
    property errFrom(logic [15:0] code, logic [15:0] prev);
        errRise(code) |-> $past(diag_code_out) == prev;
    endproperty
    property seqFrom(logic [3:0] y, logic [15:0] prev);
        seqRise(y) |-> $past(diag_code_out) == prev;
    endproperty
    chk_err_outputs:
    assert property (error_out |-> ready_out && !guard_ok_out
        && !bypass_active_out && diag_code_out[15:12] == 4'hC)
        else $error("error state outputs wrong");
    chk_code_hold:
    assert property (error_out ##1 error_out |-> $stable(diag_code_out))
        else $error("error code moved");
    chk_free_outputs:
    assert property (diag_code_out == 16'h8000 |-> ready_out && guard_ok_out
        && !bypass_active_out && !error_out) else $error("free outputs wrong");
    chk_idle_outputs:
    assert property (diag_code_out == 16'h0000 |-> !ready_out && !error_out
        && !guard_ok_out && !bypass_active_out) else $error("idle wrong");
    chk_bypass_state:
    assert property (bypass_active_out |->
        diag_code_out inside {16'h8012, 16'h8112}) else $error("bypass state");
    chk_timer_cause:
    assert property (errRise(16'hC006) |-> $past(bypass_active_out))
        else $error("timer error without bypass");
    chk_lamp_entry:
    assert property (errRise(16'hC003) |-> $past(diag_code_out) inside
        {16'h8011, 16'h8012, 16'h8122, 16'h8112}) else $error("lamp entry");
    chk_reset_one:
    assert property (errFrom(16'hC001, 16'h8001)) else $error("C001 source");
    chk_reset_two:
    assert property (errFrom(16'hC002, 16'h8003)) else $error("C002 source");
    chk_seq_free:
    assert property (seqFrom(4'h0, 16'h8000)) else $error("C0x4 source");
    chk_seq_fwd:
    assert property (seqFrom(4'h1, 16'h8011)) else $error("C1x4 source");
    chk_seq_back:
    assert property (seqFrom(4'h4, 16'h8112)) else $error("C4x4 source");
    chk_bus_ack:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1
        !wb_ack_o) else $error("ack timing");
endmodule
bind fsmm_monitor fsmm_chk #(.TICK_CYCLES(TICK_CYCLES)) u_fsmm_chk (
    .ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .guard_ok_out,
    .bypass_active_out, .ready_out, .error_out, .diag_code_out
);

// >>> test/fsmm_monitor_tb_top.sv
// Purpose: self-checking bench of the muting monitor
// Assumes: TICK_CYCLES of 10
// Notes: random sensor mixes, fixed seed
`timescale 1ns/1ps
`include "fsmm_defines.svh"
module fsmm_monitor_tb_top;
    import fsmm_pkg::*;
    logic ref_clk, rst_n, wbCyc, wbStb, wbWe, wbAck, irqOut;
    logic sA1, sA2, sB1, sB2, permit, lampOk, curtain, resetIn;
    logic guardOk, bypass, ready, errorOut;
    logic [7:0] wbAdr;
    logic [3:0] wbSel = 4'hF;
    logic [31:0] wbDatW, wbDatR, rd, seed;
    fsmm_code_t diag;
    int miscompares, checked, cycles;
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    fsmm_monitor #(.TICK_CYCLES(10)) u_fsmm_monitor (
        .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .sensor_a1(sA1),
        .sensor_a2(sA2), .sensor_b1(sB1), .sensor_b2(sB2),
        .process_permit(permit), .lamp_ok_in(lampOk), .curtain_in(curtain),
        .reset_in(resetIn), .guard_ok_out(guardOk),
        .bypass_active_out(bypass), .ready_out(ready), .error_out(errorOut),
        .diag_code_out(diag), .irq_out(irqOut));
    fsmm_field u_fsmm_field (
        .ref_clk(ref_clk), .sensor_a1(sA1), .sensor_a2(sA2), .sensor_b1(sB1),
        .sensor_b2(sB2), .process_permit(permit), .lamp_ok_in(lampOk),
        .curtain_in(curtain), .reset_in(resetIn));
    task automatic end_sim();
        $display("miscompares %0d checked %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmpCode(input fsmm_code_t got, input fsmm_code_t exp);
        cmpWord({16'h0, got}, {16'h0, exp});
    endtask
    // waits for ack; only the ceiling ends it
    task automatic wbXfer(input logic we, input logic [7:0] adr,
        input logic [31:0] dat);
        @(posedge ref_clk);
        {wbCyc, wbStb} <= 2'b11;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= dat;
        do @(posedge ref_clk); while (wbAck !== 1'b1);
        rd = wbDatR;
        {wbCyc, wbStb, wbWe} <= 3'b000;
    endtask
    function automatic logic [31:0] flags();
        return {28'h0, ready, errorOut, guardOk, bypass};
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic fsmm_code_t seqCode(input logic [3:0] y,
        input logic [3:0] x);
        return {`FSMM_SEQ_HI, y, x, `FSMM_SEQ_LO};
    endfunction
    function automatic fsmm_code_t freeNext(input logic [3:0] x);
        if (x[1] | x[2] | (x[0] & x[3])) return seqCode(`FSMM_Y_FREE, x);
        if (x == 4'h1) return `FSMM_CODE_FWDS;
        if (x == 4'h8) return `FSMM_CODE_BWDS;
        return `FSMM_CODE_FREE;
    endfunction
    task automatic expCode(input fsmm_code_t code, input int lim);
        int n = 0;
        while (diag !== code && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        cmpCode(diag, code);
    endtask
    task automatic drive(input logic [3:0] x, input fsmm_code_t code);
        u_fsmm_field.setPins(x);
        repeat (10) @(posedge ref_clk);
        expCode(code, 20);
    endtask
    task automatic recover(input int hold);
        u_fsmm_field.setPins(4'h0);
        u_fsmm_field.setCtl(1'b1, 1'b1, 1'b1);
        repeat (10) @(posedge ref_clk);
        u_fsmm_field.ackReset(hold);
        expCode(`FSMM_CODE_FREE, 30);
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        {rst_n, wbCyc, wbStb, wbWe, wbAdr, wbDatW} = '0;
        {miscompares, checked, cycles} = '0;
        seed = 32'h34C2;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        wbXfer(1'b1, `FSMM_ADR_IRQM, 32'h1);
        wbXfer(1'b1, `FSMM_ADR_CTRL, 32'h1);
        u_fsmm_field.ackReset(6);
        expCode(`FSMM_CODE_FREE, 40);
        cmpWord(flags(), 32'hA);
        drive(4'h1, `FSMM_CODE_FWDS);
        drive(4'h3, `FSMM_CODE_FWDA);
        cmpWord(flags(), 32'hB);
        drive(4'hF, `FSMM_CODE_FWDA);
        drive(4'hC, `FSMM_CODE_FWDA);
        drive(4'h8, `FSMM_CODE_FREE);
        drive(4'h1, `FSMM_CODE_FWDS);
        drive(4'h5, seqCode(`FSMM_Y_FWDS, 4'h5));
        cmpWord(flags(), 32'hC);
        cmpWord({31'h0, irqOut}, 32'h1);
        wbXfer(1'b0, `FSMM_ADR_STAT, 32'h0);
        cmpWord(rd, 32'h0003C154);
        u_fsmm_field.ackReset(6);
        repeat (10) @(posedge ref_clk);
        cmpCode(diag, seqCode(`FSMM_Y_FWDS, 4'h5));
        wbXfer(1'b0, `FSMM_ADR_IRQS, 32'h0);
        cmpWord(rd, 32'h7);
        wbXfer(1'b1, `FSMM_ADR_IRQS, 32'hF);
        wbXfer(1'b0, 8'h20, 32'h0);
        cmpWord({rd[31:1], irqOut}, 32'h0);
        recover(12);
        repeat (12) begin
            seed = xs(seed);
            drive(seed[3:0], freeNext(seed[3:0]));
            recover(6);
        end
        drive(4'h8, `FSMM_CODE_BWDS);
        drive(4'hC, `FSMM_CODE_BWDA);
        drive(4'hD, `FSMM_CODE_BWDA);
        drive(4'hC, seqCode(`FSMM_Y_BWDA, 4'hC));
        recover(6);
        u_fsmm_field.setCtl(1'b0, 1'b1, 1'b1);
        drive(4'h1, seqCode(`FSMM_Y_NOPERMIT, 4'h1));
        recover(6);
        drive(4'h1, `FSMM_CODE_FWDS);
        u_fsmm_field.setCtl(1'b1, 1'b0, 1'b1);
        expCode(`FSMM_CODE_LAMP, 20);
        recover(6);
        wbXfer(1'b1, `FSMM_ADR_MAXT, 32'h3);
        drive(4'h1, `FSMM_CODE_FWDS);
        drive(4'h3, `FSMM_CODE_FWDA);
        repeat (15) @(posedge ref_clk);
        cmpCode(diag, `FSMM_CODE_FWDA);
        expCode(`FSMM_CODE_TIMER, 60);
        cmpWord(flags(), 32'hC);
        wbXfer(1'b1, `FSMM_ADR_MAXT, `FSMM_MAXT_RST);
        recover(6);
        wbXfer(1'b1, `FSMM_ADR_MAXT, 32'h000927C1);
        expCode(`FSMM_CODE_PARAM, 20);
        wbXfer(1'b1, `FSMM_ADR_MAXT, 32'hFFFFFFFF);
        cmpCode(diag, `FSMM_CODE_PARAM);
        wbXfer(1'b1, `FSMM_ADR_MAXT, `FSMM_MAXT_LIMIT_MS);
        recover(6);
        wbSel <= 4'hE;
        wbXfer(1'b1, `FSMM_ADR_CTRL, 32'h0);
        wbSel <= 4'hF;
        u_fsmm_field.setCtl(1'b1, 1'b1, 1'b0);
        expCode(`FSMM_CODE_DEMAND, 20);
        u_fsmm_field.setReset(1'b1);
        u_fsmm_field.setCtl(1'b1, 1'b1, 1'b1);
        expCode(`FSMM_CODE_RST2, 20);
        recover(6);
        wbXfer(1'b1, `FSMM_ADR_CTRL, 32'h0);
        expCode(`FSMM_CODE_IDLE, 10);
        cmpWord(flags(), 32'h0);
        u_fsmm_field.setReset(1'b1);
        repeat (6) @(posedge ref_clk);
        wbXfer(1'b1, `FSMM_ADR_CTRL, 32'h1);
        expCode(`FSMM_CODE_RST1, 20);
        recover(6);
        end_sim();
    end
endmodule
